// ===== core_model.sv
// Processor core stand-in: instruction boundaries and interrupt re-enable
`timescale 1ns/1ps
`default_nettype none
module core_model
   import irq_pkg::*;
(
   // Clock and reset
   input  wire logic CLK_SYS,
   input  wire logic RST,
   // Block and bench handshake
   input  wire logic VEC_BUSY,
   input  wire logic EI_REQ,
   output var core_t CORE
);
   logic [1:0] cyc_reg;
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cyc_reg <= 2'h0;
         CORE    <= '0;
      end else begin
         // Three-cycle instructions, none ending while the call runs
         cyc_reg         <= (cyc_reg == 2'h2 || VEC_BUSY) ? 2'h0 : cyc_reg + 2'h1;
         CORE.instr_last <= (cyc_reg == 2'h1) && !VEC_BUSY;
         CORE.ei         <= EI_REQ;
         CORE.di         <= 1'b0;
         CORE.reti       <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== irq_pkg.sv
// Constants, field positions and carrier types of the interrupt source block
package irq_pkg;

   // Clock and timing
   localparam int CLK_NS     = 20;
   localparam int SE0_MIN_NS = 12000;
   localparam int SE0_MAX_NS = 16000;
   localparam int SE0_CYC    = (SE0_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int T128_NS    = 128000;
   localparam int T1K_NS     = 1024000;
   localparam int CALL_CYC   = 10;
   localparam int JUMP_CYC   = 5;
   localparam int INH_CYC    = 4;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_GIE      = 8'h20;
   localparam logic [7:0] IDX_EPIE     = 8'h21;
   localparam logic [7:0] IDX_I2C      = 8'h28;
   localparam logic [7:0] IDX_HUB_PEN  = 8'h49;
   localparam logic [7:0] IDX_STAT     = 8'h60;
   localparam logic [7:0] IDX_PEND     = 8'h61;
   localparam logic [7:0] IDX_GPIO_EN  = 8'h62;
   localparam logic [7:0] IDX_GPIO_POL = 8'h63;

   // Writable bits and reset values
   localparam logic [7:0]  GIE_WMASK  = 8'h6F;
   localparam logic [4:0]  EPIE_WMASK = 5'h1F;
   localparam logic [6:0]  PEN_RST    = 7'h00;

   // Global enable bit positions
   localparam int GIE_BUSRST = 0;
   localparam int GIE_T128   = 1;
   localparam int GIE_T1K    = 2;
   localparam int GIE_HUB    = 3;
   localparam int GIE_GPIO   = 5;
   localparam int GIE_I2C    = 6;

   // Status and control bit positions
   localparam int ST_MASK   = 2;
   localparam int ST_SUSP   = 3;
   localparam int ST_BUSRST = 5;
   localparam int ST_IRQ    = 7;

   // Serial controller register bit positions
   localparam int I2C_XMIT   = 0;
   localparam int I2C_ACK    = 1;
   localparam int I2C_ADDR   = 2;
   localparam int I2C_ARB    = 3;
   localparam int I2C_RSTOP  = 4;
   localparam int I2C_CONT   = 6;
   localparam int I2C_MASTER = 7;

   // Source latch positions, vector number is position plus one
   localparam int SRC_BUSRST = 0;
   localparam int SRC_T128   = 1;
   localparam int SRC_T1K    = 2;
   localparam int SRC_EP0    = 3;
   localparam int SRC_HUB    = 8;
   localparam int SRC_GPIO   = 10;
   localparam int SRC_I2C    = 11;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CALL = 2'b01,
      SEQ_JUMP = 2'b11
   } seq_t;

   typedef struct packed {
      logic instr_last;
      logic ei;
      logic di;
      logic reti;
   } core_t;

   typedef struct packed {
      logic [6:0] conn_chg;
      logic [6:0] babble;
      logic [6:0] resume;
      logic [6:0] forced;
   } hub_evt_t;

   typedef struct packed {
      logic slv_rx;
      logic first;
      logic slv_stop;
      logic slv_tx;
      logic mst_tx;
      logic mst_rx;
      logic ack_in;
      logic arb_lost;
      logic bus_stop;
   } i2c_evt_t;

   typedef struct packed {
      logic master;
      logic cont;
      logic ack;
      logic xmit;
   } i2c_ctl_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic [7:0]  gie;
      logic [4:0]  epie;
      logic [11:0] pend;
      logic        mask;
      logic        busrst;
      logic        susp;
      logic [1:0]  usb_s1;
      logic [1:0]  usb_s2;
      logic [9:0]  se0_cnt;
      logic        se0_seen;
      logic [15:0] t128_cnt;
      logic [15:0] t1k_cnt;
      logic [6:0]  pen;
      logic [15:0] gpio_s1;
      logic [15:0] gpio_s2;
      logic [15:0] gpio_en;
      logic [1:0]  gpio_pol;
      logic        gpio_lock;
      logic [3:0]  gpio_pin;
      logic [7:0]  i2c;
      logic        arb_wait;
      logic        mst_int;
      logic [2:0]  inh_cnt;
      logic        start_p;
      logic        stop_p;
      seq_t        seq;
      logic [3:0]  seq_cnt;
      logic [15:0] vec;
      logic        isr_p;
   } st_t;

endpackage

// ===== irq_sources.sv
// Interrupt source latches, priority pick and vectored call sequencing
// Notes on behaviour
// - Handler starts after 10 call, 5 jump cycles
// - Latches sampled only on last instruction cycle
// - Bus reset after 12 to 16 us SE0
// - Bus reset sets status bit 5
// - Bus reset wakes suspend, restarts oscillator
// - Two periodic timers: 128 us, 1.024 ms
// - Each endpoint event raises own interrupt
// - Hub interrupt on connect, babble, resume
// - Babble and resume gated by port enable
// - Forced port connect change raises nothing
// - GPIO pins share one vector, polarity per port
// - GPIO blocked until trigger pin goes inactive
// - Slave byte received interrupts, flags address byte
// - Slave stop sets flag and interrupts
// - Slave transmit interrupts, reports master acknowledge
// - Setting master bit starts address transmit
// - Clearing master bit after master interrupt issues stop, idles
// - Arbitration loss: clear master, interrupt at stop
// - Continue cleared before byte interrupts, firmware resets
// - Brief write inhibit after continue set
// - Lowest vector number wins priority
// - Accept: clear mask, clear latch, then call
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irq_sources
   import irq_pkg::*;
#(
   parameter int T128_CYC = T128_NS / CLK_NS,
   parameter int T1K_CYC  = T1K_NS / CLK_NS
) (
   // Clock, reset, enable
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        CE,
   // Avalon-MM register slave
   input  wire logic [9:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Processor core
   input  wire core_t       CORE,
   output logic [15:0]      VEC_ADDR,
   output logic             VEC_BUSY,
   output logic             ISR_START,
   output logic             INT_MASK,
   output logic             OSC_RUN,
   // USB upstream lines and serial engine
   input  wire logic        USB_DP,
   input  wire logic        USB_DM,
   input  wire logic [4:0]  EP_EVT,
   input  wire hub_evt_t    HUB_EVT,
   output logic [6:0]       HUB_PORT_EN,
   // GPIO pins, two ports of eight
   input  wire logic [15:0] GPIO_PIN,
   // Two-wire serial controller
   input  wire i2c_evt_t    I2C_EVT,
   output var i2c_ctl_t     I2C_CTL,
   output logic             I2C_START,
   output logic             I2C_STOP
);

   st_t st_reg;
   st_t st_next;

   // Lowest set bit: {found, index}
   function automatic logic [4:0] first_one(input logic [15:0] v);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction

   always_comb begin
      logic [7:0]  idx;
      logic        wr;
      logic        rd;
      logic [31:0] wd;
      logic [7:0]  sb;
      logic [11:0] set;
      logic [11:0] clr;
      logic [11:0] en12;
      logic [11:0] live;
      logic [4:0]  pick;
      logic [4:0]  gp;
      logic [15:0] act;
      logic        se0;
      logic        inh;
      idx  = AVS_ADDRESS[9:2];
      wr   = AVS_WRITE & st_reg.ack;
      rd   = AVS_READ & ~st_reg.ack;
      wd   = AVS_WRITEDATA;
      sb   = 8'h00;
      set  = 12'h000;
      clr  = 12'h000;
      en12 = 12'h000;
      live = 12'h000;
      pick = 5'h00;
      gp   = 5'h00;
      act  = 16'h0000;
      se0  = 1'b0;
      inh  = st_reg.inh_cnt != 3'h0;
      st_next = st_reg;

      // Bus handshake: one wait cycle, then the answer
      st_next.ack     = (AVS_READ | AVS_WRITE) & ~st_reg.ack;
      st_next.start_p = 1'b0;
      st_next.stop_p  = 1'b0;
      st_next.isr_p   = 1'b0;
      if (inh) begin
         st_next.inh_cnt = st_reg.inh_cnt - 3'h1;
      end

      // Register reads
      if (rd) begin
         if (idx == IDX_GIE) begin
            st_next.rdata = {24'h00_0000, st_reg.gie};
         end else if (idx == IDX_EPIE) begin
            st_next.rdata = {27'h000_0000, st_reg.epie};
         end else if (idx == IDX_I2C) begin
            st_next.rdata = {24'h00_0000, st_reg.i2c};
         end else if (idx == IDX_HUB_PEN) begin
            st_next.rdata = {25'h000_0000, st_reg.pen};
         end else if (idx == IDX_STAT) begin
            sb[ST_IRQ]    = |st_reg.pend;
            sb[ST_BUSRST] = st_reg.busrst;
            sb[ST_SUSP]   = st_reg.susp;
            sb[ST_MASK]   = st_reg.mask;
            st_next.rdata = {24'h00_0000, sb};
         end else if (idx == IDX_PEND) begin
            st_next.rdata = {20'h0_0000, st_reg.pend};
         end else if (idx == IDX_GPIO_EN) begin
            st_next.rdata = {16'h0000, st_reg.gpio_en};
         end else if (idx == IDX_GPIO_POL) begin
            st_next.rdata = {30'h0000_0000, st_reg.gpio_pol};
         end else begin
            st_next.rdata = 32'h0000_0000;
         end
      end

      // Register writes, hardware events below take precedence
      if (wr) begin
         if (idx == IDX_GIE) begin
            st_next.gie = wd[7:0] & GIE_WMASK;
         end else if (idx == IDX_EPIE) begin
            st_next.epie = wd[4:0] & EPIE_WMASK;
         end else if (idx == IDX_I2C) begin
            if (!inh) begin
               st_next.i2c[I2C_XMIT]   = wd[I2C_XMIT];
               st_next.i2c[I2C_ACK]    = wd[I2C_ACK];
               st_next.i2c[I2C_ADDR]   = st_reg.i2c[I2C_ADDR] & wd[I2C_ADDR];
               st_next.i2c[I2C_ARB]    = st_reg.i2c[I2C_ARB] & wd[I2C_ARB];
               st_next.i2c[I2C_RSTOP]  = st_reg.i2c[I2C_RSTOP] & wd[I2C_RSTOP];
               st_next.i2c[I2C_CONT]   = wd[I2C_CONT];
               st_next.i2c[I2C_MASTER] = wd[I2C_MASTER];
               if (wd[I2C_MASTER] && !st_reg.i2c[I2C_MASTER]) begin
                  st_next.start_p = 1'b1;
               end
               if (!wd[I2C_MASTER] && st_reg.i2c[I2C_MASTER] && st_reg.mst_int) begin
                  st_next.stop_p  = 1'b1;
                  st_next.mst_int = 1'b0;
               end
               if (wd[I2C_CONT] && !st_reg.i2c[I2C_CONT]) begin
                  st_next.inh_cnt = 3'(INH_CYC);
               end
            end
         end else if (idx == IDX_HUB_PEN) begin
            st_next.pen = wd[6:0];
         end else if (idx == IDX_STAT) begin
            if (wd[ST_BUSRST]) begin
               st_next.busrst = 1'b0;
            end
            if (wd[ST_SUSP]) begin
               st_next.susp = 1'b1;
            end
         end else if (idx == IDX_GPIO_EN) begin
            st_next.gpio_en = wd[15:0];
         end else if (idx == IDX_GPIO_POL) begin
            st_next.gpio_pol = wd[1:0];
         end
      end

      // Bus reset: SE0 held for the least detect time
      st_next.usb_s1 = {USB_DP, USB_DM};
      st_next.usb_s2 = st_reg.usb_s1;
      se0 = st_reg.usb_s2 == 2'b00;
      if (!se0) begin
         st_next.se0_cnt  = 10'h000;
         st_next.se0_seen = 1'b0;
      end else if (st_reg.se0_cnt != 10'(SE0_CYC - 1)) begin
         st_next.se0_cnt = st_reg.se0_cnt + 10'h001;
      end else if (!st_reg.se0_seen) begin
         st_next.se0_seen   = 1'b1;
         set[SRC_BUSRST]    = 1'b1;
         st_next.busrst     = 1'b1;
         st_next.susp       = 1'b0;
      end

      // Periodic timers
      if (st_reg.t128_cnt == 16'(T128_CYC - 1)) begin
         st_next.t128_cnt = 16'h0000;
         set[SRC_T128]    = 1'b1;
      end else begin
         st_next.t128_cnt = st_reg.t128_cnt + 16'h0001;
      end
      if (st_reg.t1k_cnt == 16'(T1K_CYC - 1)) begin
         st_next.t1k_cnt = 16'h0000;
         set[SRC_T1K]    = 1'b1;
      end else begin
         st_next.t1k_cnt = st_reg.t1k_cnt + 16'h0001;
      end

      // Endpoint events
      set[SRC_EP0 +: 5] = EP_EVT;

      // Hub repeater events
      set[SRC_HUB] = |(HUB_EVT.conn_chg & ~HUB_EVT.forced)
                   | |((HUB_EVT.babble | HUB_EVT.resume) & st_reg.pen);
      st_next.pen = st_next.pen & ~HUB_EVT.babble;

      // GPIO trigger with single-pin lockout
      st_next.gpio_s1 = GPIO_PIN;
      st_next.gpio_s2 = st_reg.gpio_s1;
      for (int i = 0; i < 16; i++) begin
         act[i] = st_reg.gpio_en[i] & (st_reg.gpio_s2[i] == st_reg.gpio_pol[i / 8]);
      end
      if (st_reg.gpio_lock) begin
         if (!act[st_reg.gpio_pin]) begin
            st_next.gpio_lock = 1'b0;
         end
      end else begin
         gp = first_one(act);
         if (gp[4]) begin
            set[SRC_GPIO]     = 1'b1;
            st_next.gpio_lock = 1'b1;
            st_next.gpio_pin  = gp[3:0];
         end
      end

      // Serial controller conditions
      if (I2C_EVT.slv_rx && (!st_reg.i2c[I2C_MASTER] || st_reg.i2c[I2C_ARB])) begin
         st_next.i2c[I2C_ADDR] = I2C_EVT.first;
         st_next.i2c[I2C_CONT] = 1'b0;
         set[SRC_I2C]          = 1'b1;
      end
      if (I2C_EVT.slv_stop) begin
         st_next.i2c[I2C_RSTOP] = 1'b1;
         set[SRC_I2C]           = 1'b1;
      end
      if (I2C_EVT.slv_tx || I2C_EVT.mst_tx) begin
         st_next.i2c[I2C_ACK]  = I2C_EVT.ack_in;
         st_next.i2c[I2C_CONT] = 1'b0;
         set[SRC_I2C]          = 1'b1;
      end
      if (I2C_EVT.mst_tx || I2C_EVT.mst_rx) begin
         st_next.i2c[I2C_CONT] = 1'b0;
         st_next.mst_int       = 1'b1;
         set[SRC_I2C]          = 1'b1;
      end
      if (I2C_EVT.arb_lost) begin
         st_next.i2c[I2C_MASTER] = 1'b0;
         st_next.i2c[I2C_ARB]    = 1'b1;
         st_next.arb_wait        = 1'b1;
         st_next.mst_int         = 1'b0;
      end else if (I2C_EVT.bus_stop && st_reg.arb_wait) begin
         st_next.arb_wait = 1'b0;
         set[SRC_I2C]     = 1'b1;
      end

      // Global mask from core instructions
      if (CORE.ei || CORE.reti) begin
         st_next.mask = 1'b1;
      end else if (CORE.di) begin
         st_next.mask = 1'b0;
      end

      // Priority pick among enabled pending sources
      en12[SRC_BUSRST]  = st_reg.gie[GIE_BUSRST];
      en12[SRC_T128]    = st_reg.gie[GIE_T128];
      en12[SRC_T1K]     = st_reg.gie[GIE_T1K];
      en12[SRC_EP0 +: 5] = st_reg.epie;
      en12[SRC_HUB]     = st_reg.gie[GIE_HUB];
      en12[SRC_GPIO]    = st_reg.gie[GIE_GPIO];
      en12[SRC_I2C]     = st_reg.gie[GIE_I2C];
      live = st_reg.pend & en12;
      pick = first_one({4'h0, live});
      if (|live) begin
         st_next.susp = 1'b0;
      end

      // Vectored call sequence
      case (st_reg.seq)
         SEQ_IDLE: begin
            if (CORE.instr_last && st_reg.mask && pick[4]) begin
               st_next.mask    = 1'b0;
               clr[pick[3:0]]  = 1'b1;
               st_next.vec     = {11'h000, pick[3:0] + 4'h1, 1'b0};
               st_next.seq     = SEQ_CALL;
               st_next.seq_cnt = 4'(CALL_CYC - 1);
            end
         end
         SEQ_CALL: begin
            if (st_reg.seq_cnt == 4'h0) begin
               st_next.seq     = SEQ_JUMP;
               st_next.seq_cnt = 4'(JUMP_CYC - 1);
            end else begin
               st_next.seq_cnt = st_reg.seq_cnt - 4'h1;
            end
         end
         SEQ_JUMP: begin
            if (st_reg.seq_cnt == 4'h0) begin
               st_next.seq   = SEQ_IDLE;
               st_next.isr_p = 1'b1;
            end else begin
               st_next.seq_cnt = st_reg.seq_cnt - 4'h1;
            end
         end
         default: begin
            st_next.seq = SEQ_IDLE;
         end
      endcase

      // New events win over the acknowledge clear
      st_next.pend = (st_reg.pend & ~clr) | set;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_reg <= '0;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~(st_reg.ack & CE);
   assign AVS_READDATA    = st_reg.rdata;
   assign VEC_ADDR        = st_reg.vec;
   assign VEC_BUSY        = st_reg.seq != SEQ_IDLE;
   assign ISR_START       = st_reg.isr_p;
   assign INT_MASK        = st_reg.mask;
   assign OSC_RUN         = ~st_reg.susp;
   assign HUB_PORT_EN     = st_reg.pen;
   assign I2C_CTL.master  = st_reg.i2c[I2C_MASTER];
   assign I2C_CTL.cont    = st_reg.i2c[I2C_CONT];
   assign I2C_CTL.ack     = st_reg.i2c[I2C_ACK];
   assign I2C_CTL.xmit    = st_reg.i2c[I2C_XMIT];
   assign I2C_START       = st_reg.start_p;
   assign I2C_STOP        = st_reg.stop_p;

endmodule
`default_nettype wire

// ===== irq_sources_properties.sv
// Concurrent checks on vectoring, bus answer timing and serial control bits
`timescale 1ns/1ps
`default_nettype none
module irq_sources_properties
   import irq_pkg::*;
(
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RST,
   // Register bus
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic        AVS_WAITREQUEST,
   // Core side
   input wire core_t       CORE,
   input wire logic [15:0] VEC_ADDR,
   input wire logic        VEC_BUSY,
   input wire logic        ISR_START,
   input wire logic        INT_MASK,
   // Serial controller
   input wire i2c_evt_t    I2C_EVT,
   input wire i2c_ctl_t    I2C_CTL,
   input wire logic        I2C_START,
   input wire logic        I2C_STOP
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   property p_isr_lat;
      $rose(VEC_BUSY) |-> !ISR_START [*8] ##8 ISR_START;
   endproperty
   a_isr_lat: assert property (p_isr_lat) else $error("handler start off");
   property p_busy_end;
      ISR_START |-> !VEC_BUSY && $past(VEC_BUSY);
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("call sequence end off");
   property p_mask_clr;
      $rose(VEC_BUSY) |-> !INT_MASK;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("mask kept on accept");
   property p_sample_last;
      $rose(VEC_BUSY) |-> $past(CORE.instr_last) && $past(INT_MASK);
   endproperty
   a_sample_last: assert property (p_sample_last) else $error("accept off boundary");
   property p_vec_range;
      $rose(VEC_BUSY) |-> VEC_ADDR[0] == 1'b0 && VEC_ADDR >= 16'h0002
         && VEC_ADDR <= 16'h0018 && VEC_ADDR != 16'h0014;
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("bad vector");
   property p_bus_wait;
      $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("bus answer timing");
   property p_start_mst;
      I2C_START |-> I2C_CTL.master;
   endproperty
   a_start_mst: assert property (p_start_mst) else $error("start without master");
   property p_stop_mst;
      I2C_STOP |-> !I2C_CTL.master;
   endproperty
   a_stop_mst: assert property (p_stop_mst) else $error("stop with master set");
   property p_arb_clr;
      I2C_EVT.arb_lost |=> !I2C_CTL.master;
   endproperty
   a_arb_clr: assert property (p_arb_clr) else $error("master kept on arb loss");
   property p_cont_clr;
      ((I2C_EVT.slv_rx || I2C_EVT.slv_tx) && !I2C_CTL.master) || I2C_EVT.mst_tx
         || I2C_EVT.mst_rx |=> !I2C_CTL.cont;
   endproperty
   a_cont_clr: assert property (p_cont_clr) else $error("continue not cleared");
endmodule

bind irq_sources irq_sources_properties i_irq_sources_properties (.CLK_SYS, .RST,
   .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .CORE, .VEC_ADDR, .VEC_BUSY, .ISR_START,
   .INT_MASK, .I2C_EVT, .I2C_CTL, .I2C_START, .I2C_STOP);
`default_nettype wire

// ===== test_irq_sources.sv
// Register-level tests of the interrupt source block
`timescale 1ns/1ps
`default_nettype none
module test_irq_sources;
   import irq_pkg::*;
   logic        CLK_SYS = 1'b0;
   logic        RST = 1'b1;
   logic [9:0]  AVS_ADDRESS = '0;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = '0;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   core_t       CORE;
   logic [15:0] VEC_ADDR;
   logic [6:0]  HUB_PORT_EN;
   logic        VEC_BUSY, ISR_START, INT_MASK, OSC_RUN, I2C_START, I2C_STOP;
   logic        USB_DP = 1'b1;
   logic        USB_DM = 1'b0;
   logic [4:0]  EP_EVT = '0;
   hub_evt_t    HUB_EVT = '0;
   logic [15:0] GPIO_PIN = '0;
   i2c_evt_t    I2C_EVT = '0;
   i2c_ctl_t    I2C_CTL;
   logic        ei_req = 1'b0;
   logic        stop_seen = 1'b0;
   logic [31:0] rdata;
   int          error_cnt = 0;
   int          checks = 0;
   // Pending and status first, before the first timer period sets a latch
   localparam logic [7:0] RST_IDX [7] = '{IDX_PEND, IDX_STAT, IDX_GIE, IDX_EPIE,
                                         IDX_I2C, IDX_HUB_PEN, 8'h10};

   always #10 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) if (I2C_STOP === 1'b1) stop_seen <= 1'b1;

   irq_sources #(.T128_CYC(16), .T1K_CYC(64)) i_irq_sources (.CLK_SYS, .RST, .CE(1'b1),
      .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
      .AVS_WAITREQUEST, .CORE, .VEC_ADDR, .VEC_BUSY, .ISR_START, .INT_MASK, .OSC_RUN,
      .USB_DP, .USB_DM, .EP_EVT, .HUB_EVT, .HUB_PORT_EN, .GPIO_PIN, .I2C_EVT,
      .I2C_CTL, .I2C_START, .I2C_STOP);
   core_model i_core_model (.CLK_SYS, .RST, .VEC_BUSY, .EI_REQ(ei_req), .CORE);

   task automatic end_sim;
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   // One Avalon access; the answer is taken at the edge where waitrequest is seen low
   task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge CLK_SYS);
      AVS_ADDRESS   <= {idx, 2'b00};
      AVS_WRITE     <= w;
      AVS_READ      <= !w;
      AVS_WRITEDATA <= d;
      forever begin
         @(posedge CLK_SYS);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      rdata = AVS_READDATA;
      AVS_READ  <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      acc(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx);
      acc(1'b0, idx, 32'h0000_0000);
   endtask
   task automatic service(input logic [15:0] a);
      @(posedge CLK_SYS);
      ei_req <= 1'b1;
      @(posedge CLK_SYS);
      ei_req <= 1'b0;
      repeat (60) begin
         @(negedge CLK_SYS);
         if (ISR_START === 1'b1) break;
      end
      chk(ISR_START, 1'b1);
      chk(VEC_ADDR, a);
      chk(INT_MASK, 1'b0);
   endtask
   task automatic hub(input logic [6:0] c, b, r, f);
      @(posedge CLK_SYS);
      HUB_EVT <= '{c, b, r, f};
      @(posedge CLK_SYS);
      HUB_EVT <= '0;
      rd(IDX_PEND);
   endtask
   task automatic i2c(input i2c_evt_t e, input logic [7:0] exp);
      @(posedge CLK_SYS);
      I2C_EVT <= e;
      @(posedge CLK_SYS);
      I2C_EVT <= '0;
      rd(IDX_I2C);
      chk(rdata[7:0], exp);
   endtask
   task automatic se0(input int n);
      @(posedge CLK_SYS);
      USB_DP <= 1'b0;
      tick(n);
      USB_DP <= 1'b1;
      rd(IDX_STAT);
   endtask

   initial begin
      repeat (20000) @(posedge CLK_SYS);
      error_cnt++;
      end_sim();
   end

   initial begin
      tick(4);
      RST <= 1'b0;
      foreach (RST_IDX[i]) begin
         rd(RST_IDX[i]);
         chk(rdata, 32'h0000_0000);
      end
      wr(IDX_GIE, 32'h0000_00FF);
      rd(IDX_GIE);
      chk(rdata[7:0], GIE_WMASK);
      // Priority among timers and endpoints
      wr(IDX_GIE, 32'h0000_0006);
      wr(IDX_EPIE, 32'h0000_0012);
      @(posedge CLK_SYS);
      EP_EVT <= 5'h12;
      @(posedge CLK_SYS);
      EP_EVT <= 5'h00;
      tick(70);
      rd(IDX_PEND);
      chk(rdata[11:0], 12'h096);
      service(16'h0004);
      wr(IDX_GIE, 32'h0000_0001);
      service(16'h000A);
      service(16'h0010);
      // Bus reset from suspend
      wr(IDX_STAT, 32'h0000_0008);
      tick(1);
      chk(OSC_RUN, 1'b0);
      se0(400);
      chk(rdata[ST_BUSRST], 1'b0);
      se0(820);
      chk(rdata[ST_BUSRST], 1'b1);
      chk(rdata[ST_SUSP], 1'b0);
      chk(OSC_RUN, 1'b1);
      service(16'h0002);
      wr(IDX_STAT, 32'h0000_0020);
      rd(IDX_STAT);
      chk(rdata[ST_BUSRST], 1'b0);
      // Hub events
      wr(IDX_GIE, 32'h0000_0008);
      wr(IDX_HUB_PEN, 32'h0000_0008);
      hub(7'h00, 7'h01, 7'h01, 7'h00);
      chk(rdata[SRC_HUB], 1'b0);
      chk(HUB_PORT_EN, 7'h08);
      hub(7'h04, 7'h00, 7'h00, 7'h04);
      chk(rdata[SRC_HUB], 1'b0);
      hub(7'h02, 7'h00, 7'h00, 7'h00);
      chk(rdata[SRC_HUB], 1'b1);
      service(16'h0012);
      hub(7'h00, 7'h08, 7'h00, 7'h00);
      chk(rdata[SRC_HUB], 1'b1);
      rd(IDX_HUB_PEN);
      chk(rdata[6:0], 7'h00);
      chk(HUB_PORT_EN, 7'h00);
      service(16'h0012);
      // GPIO lock on the first trigger pin
      wr(IDX_GIE, 32'h0000_0020);
      wr(IDX_GPIO_POL, 32'h0000_0001);
      wr(IDX_GPIO_EN, 32'h0000_0003);
      GPIO_PIN <= 16'h0001;
      tick(4);
      rd(IDX_PEND);
      chk(rdata[SRC_GPIO], 1'b1);
      service(16'h0016);
      GPIO_PIN <= 16'h0003;
      tick(4);
      rd(IDX_PEND);
      chk(rdata[SRC_GPIO], 1'b0);
      GPIO_PIN <= 16'h0002;
      tick(4);
      rd(IDX_PEND);
      chk(rdata[SRC_GPIO], 1'b1);
      service(16'h0016);
      // Serial controller conditions; control written at the start and after each interrupt but the first
      wr(IDX_GIE, 32'h0000_0040);
      wr(IDX_I2C, 32'h0000_0040);
      i2c(9'h180, 8'h04);
      service(16'h0018);
      i2c(9'h040, 8'h14);
      service(16'h0018);
      wr(IDX_I2C, 32'h0000_0042);
      i2c(9'h020, 8'h00);
      service(16'h0018);
      wr(IDX_I2C, 32'h0000_0080);
      i2c(9'h014, 8'h82);
      chk(I2C_CTL, 4'hA);
      service(16'h0018);
      wr(IDX_I2C, 32'h0000_0000);
      tick(2);
      chk(stop_seen, 1'b1);
      wr(IDX_I2C, 32'h0000_0080);
      i2c(9'h002, 8'h08);
      rd(IDX_PEND);
      chk(rdata[SRC_I2C], 1'b0);
      i2c(9'h001, 8'h08);
      rd(IDX_PEND);
      chk(rdata[SRC_I2C], 1'b1);
      service(16'h0018);
      wr(IDX_I2C, 32'h0000_0040);
      wr(IDX_I2C, 32'h0000_0000);
      rd(IDX_I2C);
      chk(rdata[7:0], 8'h40);
      end_sim();
   end
endmodule
`default_nettype wire
